// File: include/esd_pkg.sv
/*
  Constants, types and helpers for the extension space decoder.
  Assumes a 32-bit instruction word and a status word with flags in bits 31:28.
*/
// Functional notes
// - Load/store space: 27:25=000, bits 7,4 set
// - Exchange: 24:23=10, 21:20=00, 11:4=09
// - Exchange bit 22 picks byte, else word
// - Bit 20 set, subop 01: unsigned halfword load
// - Bit 20 set, subop 11: signed halfword load
// - Bit 20 set, subop 10: signed byte load
// - Bit 20 clear, subop 01: halfword store
// - Offset-form bit: register or split immediate offset
// - Index, up/down, writeback bits form the address
// - Other load/store space codes undefined on v4
// - Coprocessor space undefined on v4
// - 27:25=011 with bit 4 always undefined
// - Halfword store writes low 16 data bits
// - Checked misaligned halfword store raises alignment exception
// - Halfword store needs a passing condition
// - Abort leaves updated base in base register
// - Add-with-carry writes base plus operand plus carry
// - Flag update to PC restores saved status
// - Flag update sets negative, zero, carry
// - Flag update sets signed overflow
// - Bit 25 picks immediate or register operand
// - Undefined encodings raise undefined-instruction exception
////////////////////////////////////////////////////////////////////////////////
package esd_pkg;
  localparam int unsigned COND_LSB = 28;
  localparam int unsigned BIT_IMM = 25;
  localparam int unsigned BIT_PRE = 24;
  localparam int unsigned BIT_UP = 23;
  localparam int unsigned BIT_BYTE = 22;
  localparam int unsigned BIT_WB = 21;
  localparam int unsigned BIT_LOAD = 20;
  localparam int unsigned FLAG_N = 31;
  localparam int unsigned FLAG_Z = 30;
  localparam int unsigned FLAG_C = 29;
  localparam int unsigned FLAG_V = 28;
  localparam logic [2:0] LS_MAJOR = 3'h0;
  localparam logic [2:0] UNDEF_MAJOR = 3'h3;
  localparam logic [3:0] COPROC_MAJOR = 4'hc;
  localparam logic [1:0] XCHG_OP_HI = 2'h2;
  localparam logic [1:0] XCHG_OP_LO = 2'h0;
  localparam logic [7:0] XCHG_MID = 8'h09;
  localparam logic [1:0] SUB_HALF_U = 2'h1;
  localparam logic [1:0] SUB_BYTE_S = 2'h2;
  localparam logic [1:0] SUB_HALF_S = 2'h3;
  localparam logic [1:0] SUB_NONE = 2'h0;
  localparam logic [1:0] DP_MAJOR = 2'h0;
  localparam logic [3:0] ADC_OPC = 4'h5;
  localparam logic [3:0] PC_IDX = 4'hf;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    CLS_NONE, CLS_XCHG, CLS_LOAD_HU, CLS_LOAD_HS, CLS_LOAD_BS, CLS_STORE_H, CLS_ADC, CLS_UNDEF
  } esd_class_t;

  // Condition check against N, Z, C, V; code 15 never passes
  function automatic logic cond_pass(input logic [3:0] cond, input logic [3:0] nzcv);
    logic n, z, c, v;
    n = nzcv[3];
    z = nzcv[2];
    c = nzcv[1];
    v = nzcv[0];
    unique case (cond)
      4'h0: cond_pass = z;
      4'h1: cond_pass = !z;
      4'h2: cond_pass = c;
      4'h3: cond_pass = !c;
      4'h4: cond_pass = n;
      4'h5: cond_pass = !n;
      4'h6: cond_pass = v;
      4'h7: cond_pass = !v;
      4'h8: cond_pass = c && !z;
      4'h9: cond_pass = !c || z;
      4'ha: cond_pass = n == v;
      4'hb: cond_pass = n != v;
      4'hc: cond_pass = !z && (n == v);
      4'hd: cond_pass = z || (n != v);
      4'he: cond_pass = 1'b1;
      4'hf: cond_pass = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] ror32(input logic [31:0] val, input logic [4:0] amt);
    ror32 = (val >> amt) | (val << (6'h20 - {1'b0, amt}));
  endfunction
endpackage

// File: src/esd_adc_unit.sv
/*
  Three-input adder for add-with-carry with its flag results.
  Purely combinational; the caller registers everything it uses.
*/
`timescale 1ns/1ns
`default_nettype none
module esd_adc_unit (
  input wire logic [31:0] base_in,
  input wire logic [31:0] operand_in,
  input wire logic carry_in,
  output logic [31:0] sum_out,
  output logic neg_out,
  output logic zero_out,
  output logic carry_out,
  output logic ovf_out
);
  logic [32:0] wide;

  always_comb begin
    wide = {1'b0, base_in} + {1'b0, operand_in} + {32'h0, carry_in};
    sum_out = wide[31:0];
    neg_out = wide[31];
    zero_out = wide[31:0] == 32'h0;
    carry_out = wide[32];
    // Overflow when both inputs agree in sign and the result does not
    ovf_out = (base_in[31] == operand_in[31]) && (wide[31] != base_in[31]);
  end
endmodule
`default_nettype wire

// File: src/esd_decoder.sv
/*
  Extension space decoder and executor: exchange, halfword and signed-byte
  transfers, halfword store, add-with-carry, undefined detection.
  Assumes register values are read by the pipeline in the decode cycle and
  that OFFSET_VAL_IN already carries any shift on the register operand.
*/
`timescale 1ns/1ns
`default_nettype none
module esd_decoder
  import esd_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic INSTR_VALID_IN,
  input wire logic [31:0] INSTR_IN,
  input wire logic ARCH_V4_IN,
  input wire logic SYSCTL_PRESENT_IN,
  input wire logic ALIGN_CHECK_EN_IN,
  input wire logic [31:0] BASE_VAL_IN,
  input wire logic [31:0] DATA_VAL_IN,
  input wire logic [31:0] OFFSET_VAL_IN,
  input wire logic [31:0] SAVED_STATUS_IN,
  output logic [2:0] CLASS_OUT,
  output logic UNDEF_EXC_OUT,
  output logic ALIGN_EXC_OUT,
  output logic MEM_REQ_OUT,
  output logic MEM_WRITE_OUT,
  output logic XCHG_OUT,
  output logic MEM_SIGNED_OUT,
  output logic [1:0] MEM_SIZE_OUT,
  output logic [31:0] MEM_ADDR_OUT,
  output logic [31:0] MEM_WDATA_OUT,
  output logic [3:0] LOAD_REG_OUT,
  output logic BASE_WB_OUT,
  output logic [3:0] BASE_REG_OUT,
  output logic [31:0] BASE_WB_VAL_OUT,
  output logic RD_WE_OUT,
  output logic [3:0] RD_IDX_OUT,
  output logic [31:0] RD_WDATA_OUT,
  output logic [31:0] STATUS_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction and classification
  logic [3:0] cond_f;
  logic [3:0] base_f;
  logic [3:0] targ_f;
  logic [3:0] hoff_f;
  logic [3:0] offr_f;
  logic [1:0] subop_f;
  logic in_ls_space;
  logic in_cp_space;
  logic in_undef_space;
  logic is_xchg;
  logic is_ld_hu;
  logic is_ld_hs;
  logic is_ld_bs;
  logic is_st_h;
  logic ls_other;
  logic is_adc;
  logic undef_hit;
  logic pass;
  logic exec;
  esd_class_t cls;

  logic [31:0] status_r;
  logic [31:0] status_nxt;

  always_comb begin
    cond_f = INSTR_IN[31:COND_LSB];
    base_f = INSTR_IN[19:16];
    targ_f = INSTR_IN[15:12];
    hoff_f = INSTR_IN[11:8];
    offr_f = INSTR_IN[3:0];
    subop_f = INSTR_IN[6:5];
    in_ls_space = (INSTR_IN[27:25] == LS_MAJOR) && INSTR_IN[7] && INSTR_IN[4]
      && !(!INSTR_IN[BIT_PRE] && (subop_f == SUB_NONE));
    is_xchg = in_ls_space && (INSTR_IN[24:23] == XCHG_OP_HI)
      && (INSTR_IN[21:20] == XCHG_OP_LO) && (INSTR_IN[11:4] == XCHG_MID);
    is_ld_hu = in_ls_space && INSTR_IN[BIT_LOAD] && (subop_f == SUB_HALF_U);
    is_ld_hs = in_ls_space && INSTR_IN[BIT_LOAD] && (subop_f == SUB_HALF_S);
    is_ld_bs = in_ls_space && INSTR_IN[BIT_LOAD] && (subop_f == SUB_BYTE_S);
    is_st_h = in_ls_space && !INSTR_IN[BIT_LOAD] && (subop_f == SUB_HALF_U);
    ls_other = in_ls_space && !(is_xchg || is_ld_hu || is_ld_hs || is_ld_bs || is_st_h);
    in_cp_space = (INSTR_IN[27:24] == COPROC_MAJOR) && !INSTR_IN[BIT_WB];
    in_undef_space = (INSTR_IN[27:25] == UNDEF_MAJOR) && INSTR_IN[4];
    // Before v4 these encodings have no behaviour; they are quietly dropped
    undef_hit = in_undef_space
      || (ARCH_V4_IN && ls_other)
      || (ARCH_V4_IN && in_cp_space);
    is_adc = (INSTR_IN[27:26] == DP_MAJOR) && (INSTR_IN[24:21] == ADC_OPC)
      && !(!INSTR_IN[BIT_IMM] && INSTR_IN[7] && INSTR_IN[4]);
    pass = cond_pass(cond_f, status_r[31:28]);
    exec = INSTR_VALID_IN && pass && !undef_hit;
    // Decided in the same cycle the word is presented
    if (undef_hit) begin
      cls = CLS_UNDEF;
    end else if (is_xchg) begin
      cls = CLS_XCHG;
    end else if (is_ld_hu) begin
      cls = CLS_LOAD_HU;
    end else if (is_ld_hs) begin
      cls = CLS_LOAD_HS;
    end else if (is_ld_bs) begin
      cls = CLS_LOAD_BS;
    end else if (is_st_h) begin
      cls = CLS_STORE_H;
    end else if (is_adc) begin
      cls = CLS_ADC;
    end else begin
      cls = CLS_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operands and addressing
  logic [31:0] shifter_op;
  logic [31:0] hw_offset;
  logic [31:0] offs_addr;
  logic [31:0] xfer_addr;
  logic wb_req;
  logic [31:0] adc_sum;
  logic adc_n;
  logic adc_z;
  logic adc_c;
  logic adc_v;

  always_comb begin
    shifter_op = INSTR_IN[BIT_IMM]
      ? ror32({24'h0, INSTR_IN[7:0]}, {INSTR_IN[11:8], 1'b0})
      : OFFSET_VAL_IN;
    hw_offset = INSTR_IN[BIT_BYTE] ? {24'h0, hoff_f, offr_f} : OFFSET_VAL_IN;
    offs_addr = INSTR_IN[BIT_UP] ? BASE_VAL_IN + hw_offset : BASE_VAL_IN - hw_offset;
    xfer_addr = INSTR_IN[BIT_PRE] ? offs_addr : BASE_VAL_IN;
    wb_req = !INSTR_IN[BIT_PRE] || INSTR_IN[BIT_WB];
  end

  esd_adc_unit u_adc (
    .base_in(BASE_VAL_IN),
    .operand_in(shifter_op),
    .carry_in(status_r[FLAG_C]),
    .sum_out(adc_sum),
    .neg_out(adc_n),
    .zero_out(adc_z),
    .carry_out(adc_c),
    .ovf_out(adc_v)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state computation
  logic [2:0] class_r, class_nxt;
  logic undef_r, undef_nxt;
  logic align_r, align_nxt;
  logic req_r, req_nxt;
  logic write_r, write_nxt;
  logic xchg_r, xchg_nxt;
  logic signed_r, signed_nxt;
  logic [1:0] size_r, size_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] load_reg_r, load_reg_nxt;
  logic wb_r, wb_nxt;
  logic [3:0] base_reg_r, base_reg_nxt;
  logic [31:0] wb_val_r, wb_val_nxt;
  logic rd_we_r, rd_we_nxt;
  logic [3:0] rd_idx_r, rd_idx_nxt;
  logic [31:0] rd_data_r, rd_data_nxt;
  logic misalign_trap;

  always_comb begin
    class_nxt = INSTR_VALID_IN ? cls : CLS_NONE;
    undef_nxt = INSTR_VALID_IN && undef_hit;
    req_nxt = 1'b0;
    write_nxt = 1'b0;
    xchg_nxt = 1'b0;
    signed_nxt = 1'b0;
    size_nxt = SIZE_WORD;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    load_reg_nxt = targ_f;
    wb_nxt = 1'b0;
    base_reg_nxt = base_f;
    wb_val_nxt = offs_addr;
    rd_we_nxt = 1'b0;
    rd_idx_nxt = targ_f;
    rd_data_nxt = rd_data_r;
    status_nxt = status_r;
    misalign_trap = SYSCTL_PRESENT_IN && ALIGN_CHECK_EN_IN && xfer_addr[0];
    align_nxt = exec && is_st_h && misalign_trap;
    if (exec && is_xchg) begin
      req_nxt = 1'b1;
      xchg_nxt = 1'b1;
      addr_nxt = BASE_VAL_IN;
      wdata_nxt = OFFSET_VAL_IN;
      size_nxt = INSTR_IN[BIT_BYTE] ? SIZE_BYTE : SIZE_WORD;
    end else if (exec && (is_ld_hu || is_ld_hs || is_ld_bs)) begin
      req_nxt = 1'b1;
      addr_nxt = xfer_addr;
      signed_nxt = !is_ld_hu;
      size_nxt = is_ld_bs ? SIZE_BYTE : SIZE_HALF;
      wb_nxt = wb_req;
    end else if (exec && is_st_h && !misalign_trap) begin
      req_nxt = 1'b1;
      write_nxt = 1'b1;
      size_nxt = SIZE_HALF;
      addr_nxt = xfer_addr;
      // Unchecked misaligned stores still go out; the result is unpredictable
      wdata_nxt = {16'h0, DATA_VAL_IN[15:0]};
      // Base update goes out with the request, so an abort leaves it updated
      wb_nxt = wb_req;
    end else if (exec && is_adc) begin
      rd_we_nxt = 1'b1;
      rd_data_nxt = adc_sum;
      if (INSTR_IN[BIT_LOAD] && (targ_f == PC_IDX)) begin
        status_nxt = SAVED_STATUS_IN;
      end else if (INSTR_IN[BIT_LOAD]) begin
        status_nxt[FLAG_N] = adc_n;
        status_nxt[FLAG_Z] = adc_z;
        status_nxt[FLAG_C] = adc_c;
        status_nxt[FLAG_V] = adc_v;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      class_r <= CLS_NONE;
      undef_r <= 1'b0;
      align_r <= 1'b0;
      req_r <= 1'b0;
      write_r <= 1'b0;
      xchg_r <= 1'b0;
      signed_r <= 1'b0;
      size_r <= SIZE_WORD;
      addr_r <= 32'h0;
      wdata_r <= 32'h0;
      load_reg_r <= 4'h0;
      wb_r <= 1'b0;
      base_reg_r <= 4'h0;
      wb_val_r <= 32'h0;
      rd_we_r <= 1'b0;
      rd_idx_r <= 4'h0;
      rd_data_r <= 32'h0;
      status_r <= STATUS_RST;
    end else begin
      class_r <= class_nxt;
      undef_r <= undef_nxt;
      align_r <= align_nxt;
      req_r <= req_nxt;
      write_r <= write_nxt;
      xchg_r <= xchg_nxt;
      signed_r <= signed_nxt;
      size_r <= size_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      load_reg_r <= load_reg_nxt;
      wb_r <= wb_nxt;
      base_reg_r <= base_reg_nxt;
      wb_val_r <= wb_val_nxt;
      rd_we_r <= rd_we_nxt;
      rd_idx_r <= rd_idx_nxt;
      rd_data_r <= rd_data_nxt;
      status_r <= status_nxt;
    end
  end

  always_comb begin
    CLASS_OUT = class_r;
    UNDEF_EXC_OUT = undef_r;
    ALIGN_EXC_OUT = align_r;
    MEM_REQ_OUT = req_r;
    MEM_WRITE_OUT = write_r;
    XCHG_OUT = xchg_r;
    MEM_SIGNED_OUT = signed_r;
    MEM_SIZE_OUT = size_r;
    MEM_ADDR_OUT = addr_r;
    MEM_WDATA_OUT = wdata_r;
    LOAD_REG_OUT = load_reg_r;
    BASE_WB_OUT = wb_r;
    BASE_REG_OUT = base_reg_r;
    BASE_WB_VAL_OUT = wb_val_r;
    RD_WE_OUT = rd_we_r;
    RD_IDX_OUT = rd_idx_r;
    RD_WDATA_OUT = rd_data_r;
    STATUS_OUT = status_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking dcb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (SRST_IN);

  sequence adc_flag_issue;
    INSTR_VALID_IN && is_adc && pass && !undef_hit && INSTR_IN[BIT_LOAD];
  endsequence

  sequence store_issue;
    INSTR_VALID_IN && is_st_h && pass && !undef_hit;
  endsequence

  undef_space_a: assert property (
    INSTR_VALID_IN && (INSTR_IN[27:25] == 3'h3) && INSTR_IN[4]
      |=> UNDEF_EXC_OUT && !MEM_REQ_OUT && !RD_WE_OUT)
    else $error("Permanently undefined word did not trap");

  coproc_undef_a: assert property (
    INSTR_VALID_IN && ARCH_V4_IN && (INSTR_IN[27:24] == 4'hc) && !INSTR_IN[21]
      |=> UNDEF_EXC_OUT ##1 !UNDEF_EXC_OUT || $past(INSTR_VALID_IN))
    else $error("Coprocessor space word did not trap once");

  xchg_size_a: assert property (
    INSTR_VALID_IN && is_xchg && pass && !undef_hit
      |=> MEM_REQ_OUT && XCHG_OUT && !MEM_WRITE_OUT
        && MEM_SIZE_OUT == ($past(INSTR_IN[22]) ? SIZE_BYTE : SIZE_WORD)
        && MEM_ADDR_OUT == $past(BASE_VAL_IN))
    else $error("Exchange request wrong size or address");

  store_data_a: assert property (
    store_issue ##0 !(SYSCTL_PRESENT_IN && ALIGN_CHECK_EN_IN && xfer_addr[0])
      |=> MEM_REQ_OUT && MEM_WRITE_OUT && MEM_SIZE_OUT == SIZE_HALF
        && MEM_WDATA_OUT == {16'h0, $past(DATA_VAL_IN[15:0])})
    else $error("Halfword store data not low half of data register");

  align_trap_a: assert property (
    store_issue ##0 SYSCTL_PRESENT_IN && ALIGN_CHECK_EN_IN && xfer_addr[0]
      |=> ALIGN_EXC_OUT && !MEM_REQ_OUT && !BASE_WB_OUT)
    else $error("Misaligned checked store not trapped");

  cond_fail_a: assert property (
    INSTR_VALID_IN && !pass |=> !MEM_REQ_OUT && !RD_WE_OUT && $stable(STATUS_OUT))
    else $error("Failed condition still had an effect");

  adc_sum_a: assert property (
    INSTR_VALID_IN && is_adc && pass && !undef_hit
      |=> RD_WE_OUT && RD_WDATA_OUT
        == $past(BASE_VAL_IN) + $past(shifter_op) + {31'h0, $past(status_r[FLAG_C])})
    else $error("Add-with-carry result wrong");

  restore_a: assert property (
    adc_flag_issue ##0 (INSTR_IN[15:12] == 4'hf) |=> STATUS_OUT == $past(SAVED_STATUS_IN))
    else $error("Saved status not restored");

  zero_flag_a: assert property (
    adc_flag_issue ##0 (INSTR_IN[15:12] != 4'hf)
      |=> STATUS_OUT[FLAG_Z] == (RD_WDATA_OUT == 32'h0) && STATUS_OUT[FLAG_N] == RD_WDATA_OUT[31])
    else $error("Negative or zero flag wrong");

  ls_undef_a: assert property (
    INSTR_VALID_IN && ls_other |=> UNDEF_EXC_OUT == $past(ARCH_V4_IN) && !MEM_REQ_OUT)
    else $error("Unassigned load/store code handled wrongly");

endmodule
`default_nettype wire

// File: test/esd_mem_model.sv
/*
  Memory side partner: takes fire-and-forget requests and keeps the last write.
  Assumes the core clock and the registered one-cycle request pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module esd_mem_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic xchg_in,
  input wire logic [1:0] size_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] last_addr_out,
  output logic [31:0] last_data_out,
  output logic [7:0] write_count_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // Only the lanes of the access size land, so stray upper bits stay unseen
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      last_addr_out <= 32'h0;
      last_data_out <= 32'h0;
      write_count_out <= 8'h0;
    end else if (req_in && (write_in || xchg_in)) begin
      last_addr_out <= addr_in;
      write_count_out <= write_count_out + 8'h1;
      case (size_in)
        2'h0: last_data_out <= {24'h0, wdata_in[7:0]};
        2'h1: last_data_out <= {16'h0, wdata_in[15:0]};
        default: last_data_out <= wdata_in;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: test/test_extension_space_decoder.sv
/*
  Self-checking bench for the extension space decoder.
  Assumes one core clock and a one-cycle registered answer to each word.
*/
`timescale 1ns/1ns
`default_nettype none
module test_extension_space_decoder;
  import esd_pkg::*;
  localparam int DLY = 2;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic valid = 1'b0;
  logic v4 = 1'b1;
  logic sysctl = 1'b0;
  logic align_en = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [31:0] base = 32'h0;
  logic [31:0] data = 32'h0;
  logic [31:0] offs = 32'h0;
  logic [31:0] saved = 32'h0;
  logic [2:0] cls;
  logic undef, align, req, wr, xchg, sgn, bwb, rdwe;
  logic [1:0] size;
  logic [31:0] addr, wdata, bwb_val, rdata, status, m_addr, m_data;
  logic [3:0] ld_reg, b_reg, rd_idx;
  logic [7:0] m_cnt;
  int fail_count = 0;
  int total_checks = 0;

  initial begin
    forever #25 clk = ~clk;
  end

  esd_decoder dut (.SYS_CLK_IN(clk), .SRST_IN(srst), .INSTR_VALID_IN(valid),
    .INSTR_IN(instr), .ARCH_V4_IN(v4), .SYSCTL_PRESENT_IN(sysctl),
    .ALIGN_CHECK_EN_IN(align_en), .BASE_VAL_IN(base), .DATA_VAL_IN(data),
    .OFFSET_VAL_IN(offs), .SAVED_STATUS_IN(saved), .CLASS_OUT(cls),
    .UNDEF_EXC_OUT(undef), .ALIGN_EXC_OUT(align), .MEM_REQ_OUT(req),
    .MEM_WRITE_OUT(wr), .XCHG_OUT(xchg), .MEM_SIGNED_OUT(sgn), .MEM_SIZE_OUT(size),
    .MEM_ADDR_OUT(addr), .MEM_WDATA_OUT(wdata), .LOAD_REG_OUT(ld_reg),
    .BASE_WB_OUT(bwb), .BASE_REG_OUT(b_reg), .BASE_WB_VAL_OUT(bwb_val),
    .RD_WE_OUT(rdwe), .RD_IDX_OUT(rd_idx), .RD_WDATA_OUT(rdata), .STATUS_OUT(status));

  esd_mem_model mem (.clk_in(clk), .rst_in(srst), .req_in(req), .write_in(wr),
    .xchg_in(xchg), .size_in(size), .addr_in(addr), .wdata_in(wdata),
    .last_addr_out(m_addr), .last_data_out(m_data), .write_count_out(m_cnt));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Valid stays up between words so back-to-back words need no gap
  task automatic step(input logic [31:0] w, input logic [31:0] b, input logic [31:0] d,
      input logic [31:0] o);
    valid = 1'b1;
    instr = w;
    base = b;
    data = d;
    offs = o;
    @(posedge clk);
    #DLY;
  endtask

  task automatic idle();
    valid = 1'b0;
    @(posedge clk);
    #DLY;
  endtask

  function automatic logic [31:0] adc_w(input logic [3:0] c, input logic i, input logic s,
      input logic [3:0] rd, input logic [11:0] op2);
    adc_w = {c, 2'h0, i, ADC_OPC, s, 4'h1, rd, op2};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    idle();
    chk(32'(cls), 32'h0, "rst cls");
    chk(32'(size), 32'h2, "rst size");
    chk(status, 32'h0, "rst status");
    chk(32'(req | undef | align | bwb | rdwe), 32'h0, "rst pulses");
  endtask

  task automatic test_store();
    // Data register is neither the base nor the program counter
    step(32'he1e341b4, 32'h1000, 32'hdeadbeef, 32'h0);
    chk(32'(cls), 32'h5, "st cls");
    chk(32'(req & wr & bwb), 32'h1, "st req");
    chk(32'(size), 32'h1, "st size");
    chk(addr, 32'h1014, "st addr");
    chk(wdata, 32'h0000beef, "st data");
    chk(32'(b_reg), 32'h3, "st base");
    chk(bwb_val, 32'h1014, "st wb");
    step(32'he00560b7, 32'h2000, 32'h12345678, 32'h10);
    chk(addr, 32'h2000, "post addr");
    chk(bwb_val, 32'h1ff0, "post wb");
    chk(32'(bwb), 32'h1, "post wbp");
    // Load bit clear: this one must stay a store for the memory check below
    step(32'he10560b7, 32'h2000, 32'h12345678, 32'h10);
    chk(32'(cls), 32'h5, "pre dn cls");
    chk(addr, 32'h1ff0, "pre dn addr");
    chk(32'(bwb), 32'h0, "no wb");
    idle();
    chk(32'(req | bwb), 32'h0, "st pulse");
    chk(m_addr, 32'h1ff0, "mem addr");
    chk(m_data, 32'h00005678, "mem data");
  endtask

  task automatic test_cond();
    logic [7:0] c0;
    c0 = m_cnt;
    // Zero flag clear after reset, so the equal condition fails
    step(32'h01e341b4, 32'h1000, 32'h1, 32'h0);
    chk(32'(cls), 32'h5, "cf cls");
    chk(32'(req | bwb), 32'h0, "cf quiet");
    idle();
    chk(32'(m_cnt), 32'(c0), "cf mem");
  endtask

  task automatic test_loads();
    for (int i = 1; i < 4; i++) begin
      step(32'he1d29092 | (32'(i) << 5), 32'h40, 32'h0, 32'h0);
      chk(32'(cls), (i == 1) ? 32'h2 : (i == 3) ? 32'h3 : 32'h4, "ld cls");
      chk(32'(sgn), 32'(i != 1), "ld sign");
      chk(32'(size), (i == 2) ? 32'h0 : 32'h1, "ld size");
      chk(addr, 32'h42, "ld addr");
      chk(32'(req & ~wr), 32'h1, "ld req");
      chk(32'(ld_reg), 32'h9, "ld dest");
    end
    idle();
  endtask

  task automatic test_xchg();
    for (int b = 0; b < 2; b++) begin
      step(32'he1081092 | (32'(b) << 22), 32'h3000, 32'h0, 32'hcafef00d);
      chk(32'(cls), 32'h1, "xc cls");
      chk(32'(req & xchg & ~bwb), 32'h1, "xc req");
      chk(addr, 32'h3000, "xc addr");
      chk(32'(size), (b == 1) ? 32'h0 : 32'h2, "xc size");
      chk(32'(ld_reg), 32'h1, "xc dest");
      if (b == 0)
        chk(wdata, 32'hcafef00d, "xc data");
    end
    idle();
    chk(m_data, 32'h0000000d, "xc byte");
  endtask

  task automatic test_undef();
    logic [31:0] w [6] = '{32'he1000f90, 32'he00000d0, 32'he00000f0, 32'hec000000,
      32'he6000010, 32'hf6000010};
    for (int v = 0; v < 2; v++) begin
      for (int i = 0; i < 6; i++) begin
        v4 = v[0];
        step(w[i], 32'h0, 32'h0, 32'h0);
        chk(32'(undef), 32'((v == 1) || (i >= 4)), "undef");
        chk(32'(req | rdwe), 32'h0, "ud quiet");
        if ((v == 1) || (i >= 4))
          chk(32'(cls), 32'h7, "ud cls");
      end
    end
    idle();
    chk(32'(undef), 32'h0, "ud pulse");
  endtask

  task automatic test_align();
    for (int i = 0; i < 3; i++) begin
      sysctl = (i != 2);
      align_en = (i != 1);
      step(32'he1c340b1, 32'h1000, 32'h1234, 32'h0);
      chk(32'(align), 32'(i == 0), "al exc");
      if (i == 1)
        chk(addr, 32'h1001, "odd addr");
    end
    idle();
    chk(32'(align), 32'h0, "al pulse");
  endtask

  task automatic test_adc();
    step(adc_w(4'he, 1'b0, 1'b1, 4'h2, 12'h0), 32'hffffffff, 32'h0, 32'h1);
    chk(rdata, 32'h0, "adc sum");
    chk(32'(status[31:28]), 32'h6, "adc zc");
    chk(32'(rdwe), 32'h1, "adc we");
    chk(32'(cls), 32'h6, "adc cls");
    step(adc_w(4'he, 1'b1, 1'b0, 4'h3, 12'h4ff), 32'h1, 32'h0, 32'h0);
    chk(rdata, 32'hff000002, "adc imm");
    chk(32'(rd_idx), 32'h3, "adc dest");
    chk(32'(status[31:28]), 32'h6, "no s");
    step(adc_w(4'he, 1'b0, 1'b1, 4'h4, 12'h0), 32'h7fffffff, 32'h0, 32'h0);
    chk(rdata, 32'h80000000, "adc ovf");
    chk(32'(status[31:28]), 32'h9, "adc nv");
    saved = 32'h50000010;
    step(adc_w(4'he, 1'b0, 1'b1, 4'hf, 12'h0), 32'h0, 32'h0, 32'h0);
    chk(status, 32'h50000010, "restore");
    step(adc_w(4'h1, 1'b0, 1'b1, 4'h5, 12'h0), 32'h1, 32'h0, 32'h0);
    chk(32'(rdwe), 32'h0, "adc cf");
    chk(status, 32'h50000010, "cf keep");
    idle();
    chk(32'(rdwe), 32'h0, "adc pulse");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    #DLY;
    srst = 1'b0;
    test_reset();
    test_store();
    test_cond();
    test_loads();
    test_xchg();
    test_undef();
    test_align();
    test_adc();
    print_verdict();
  end

  // The whole sequence takes well under a hundred cycles
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    $display("unexpected at %0t: run hung", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
